// ### design/bcp_pkg.sv
// shared constants and types for the brushless commutation and protection block
package bcp_pkg;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int STOP_MIN_NS = 10000;
    localparam int STOP_MIN_CYC = (STOP_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DEAD_NS = 1000;
    localparam int DEAD_CYC = (DEAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LOCK_TIME_MS = 1540;
    localparam int LOCK_TIME_CYC = LOCK_TIME_MS * (1000000000 / CLK_PERIOD_PS);
    localparam int CLR_UNIT_MS = 5;
    localparam int CLR_UNIT_CYC = CLR_UNIT_MS * (1000000000 / CLK_PERIOD_PS);
    localparam int REV_STEPS = 3;
    // compare input and carrier are in millivolts
    localparam logic [11:0] CMP_UPPER_MV = 12'hbb8;
    localparam logic [11:0] CMP_LOWER_MV = 12'h4b0;
    localparam logic [11:0] CARRIER_STEP = 12'h004;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_LOCK = 4'h4;
    localparam logic [3:0] OFS_CLR = 4'h8;
    localparam logic [3:0] OFS_STAT = 4'hc;
    localparam int CTRL_DIR_BIT = 0;
    localparam int CTRL_LOCK_OFF_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam int ST_LOCK_BIT = 0;
    localparam int ST_REV_BIT = 1;
    localparam int ST_UV_BIT = 2;
    localparam int ST_TSD_BIT = 3;
    localparam int ST_HALL_LSB = 4;
    localparam int ST_MODE_LSB = 8;
    typedef struct packed {
        logic [2:0] upper;
        logic [2:0] lower;
    } bcp_drive_s;
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bcp_bus_s;
    typedef enum logic [1:0] {MODE_STOP, MODE_DEAD, MODE_RUN, MODE_BRAKE} bcp_mode_e;
    // index {reverse, hall3, hall2, hall1}; value {upper wvu, lower wvu}
    localparam logic [15:0][5:0] COMM_TABLE = {
        6'h00, 6'h11, 6'h0c, 6'h14, 6'h0a, 6'h22, 6'h21, 6'h00,
        6'h00, 6'h0a, 6'h21, 6'h11, 6'h14, 6'h0c, 6'h22, 6'h00};
endpackage

// ### design/bcp_top.sv
// commutation, duty and protection logic of a three-phase brushless pre-driver
// Behaviour
// - pulse duty input low enables drive, high turns drive off.
// - compare input above upper carrier gives 0% duty, below lower gives 100%.
// - all three hall inputs high turns off all six outputs.
// - undervoltage turns off upper outputs until the detector clears.
// - no hall change within lock timeout while driving latches lock fault, upper off.
// - lock fault clears on stop held, zero duty beyond twice unit, or reset.
// - grounded lock timer node holds logic in reset, motor not driven.
// - lock protection unused also disables reverse and overheat protection.
// - reverse protection enabled only while reverse guard select is low.
// - reverse protection enabled and zero duty turns all six outputs off.
// - reversal judged when halls step backward more than 120 degrees.
// - reversal persisting one lock timeout turns all outputs off.
// - backward rotation at drive start gets one lock timeout to turn forward.
// - reverse shutdown clears on stop held, zero duty beyond twice unit, or reset.
// - thermal shutdown turns off the upper outputs.
// - direction change inserts an off interval before the new pattern.
// - brake turns all upper on, lower off, with off interval at entry and exit.
// - braking suspends current limiting and lock detection.
// - run-stop select low runs, high stops.
// - stop mode puts all six outputs in high impedance.
// - duty modulation only on upper outputs, lower follow commutation.
// - overcurrent shortens the present on-pulse.
`timescale 1ns/10ps
`default_nettype none
module bcp_top #(
    parameter int LOCK_TIMEOUT_CYC = bcp_pkg::LOCK_TIME_CYC,
    parameter int CLEAR_UNIT_CYC = bcp_pkg::CLR_UNIT_CYC,
    parameter logic [15:0][5:0] DRIVE_TABLE = bcp_pkg::COMM_TABLE
) (
    input wire logic clk,
    input wire logic rst,
    input wire bcp_pkg::bcp_bus_s bus_req,
    output logic [31:0] reg_rdata,
    input wire logic hall_phase_one,
    input wire logic hall_phase_two,
    input wire logic hall_phase_three,
    input wire logic pulse_duty_input_n,
    input wire logic [11:0] duty_compare_input,
    input wire logic run_stop_select,
    input wire logic brake_request_n,
    input wire logic reverse_guard_select_n,
    input wire logic undervoltage_sense,
    input wire logic thermal_shutdown_limit,
    input wire logic overcurrent_sense,
    input wire logic lock_timer_node_n,
    output logic upper_drive_u,
    output logic upper_drive_v,
    output logic upper_drive_w,
    output logic lower_drive_u,
    output logic lower_drive_v,
    output logic lower_drive_w,
    output logic drive_oe,
    output logic hall_composite_out
);
    import bcp_pkg::*;

    if (LOCK_TIMEOUT_CYC < 1 || CLEAR_UNIT_CYC < 1) begin : g_chk
        $error("lock timeout and clear unit must be at least one cycle");
    end

    bcp_mode_e mode_reg, mode_next;
    bcp_drive_s drv_reg, drv_next, pat;
    logic [1:0] ctrl_reg;
    logic [31:0] lock_to_reg, clr_unit_reg, rdata_next;
    logic [2:0] hall_q_reg;
    logic dir_reg, oe_reg, hcomp_reg;
    logic [11:0] carrier_reg;
    logic oc_cut_reg, lock_fault_reg, rev_fault_reg;
    logic [31:0] lock_cnt_reg, rev_cnt_reg;
    logic [32:0] zero_cnt_reg;
    logic [15:0] stop_cnt_reg, dead_cnt_reg;
    logic [1:0] back_cnt_reg;

    function automatic logic [2:0] hall_step(input logic [2:0] h);
        case (h)
            3'h1: hall_step = 3'h0;
            3'h3: hall_step = 3'h1;
            3'h2: hall_step = 3'h2;
            3'h6: hall_step = 3'h3;
            3'h4: hall_step = 3'h4;
            3'h5: hall_step = 3'h5;
            default: hall_step = 3'h7;
        endcase
    endfunction

    // hall decode
    wire [2:0] hall = {hall_phase_three, hall_phase_two, hall_phase_one};
    wire hall_chg = hall != hall_q_reg;
    wire hall_all = &hall;
    wire [2:0] step_now = hall_step(hall);
    wire [2:0] step_old = hall_step(hall_q_reg);
    wire step_ok = step_now != 3'h7 && step_old != 3'h7;
    wire [2:0] step_fwd = (step_old == 3'h5) ? 3'h0 : step_old + 3'h1;
    wire [2:0] step_bwd = (step_old == 3'h0) ? 3'h5 : step_old - 3'h1;
    // backward is relative to the selected direction
    wire step_back = step_ok && hall_chg && (step_now == (dir_reg ? step_fwd : step_bwd));
    wire step_ahead = step_ok && hall_chg && (step_now == (dir_reg ? step_bwd : step_fwd));
    wire rev_judged = back_cnt_reg == 2'(REV_STEPS);

    // duty generation
    wire carrier_wrap = carrier_reg >= CMP_UPPER_MV - CARRIER_STEP;
    wire [11:0] carrier_next = carrier_wrap ? CMP_LOWER_MV : carrier_reg + CARRIER_STEP;
    wire cmp_on = duty_compare_input < carrier_reg;
    wire duty_on = ~pulse_duty_input_n & cmp_on;
    wire duty_zero = pulse_duty_input_n | (duty_compare_input >= CMP_UPPER_MV);

    // protection enables
    wire kill = ~lock_timer_node_n;
    wire prot_on = ~ctrl_reg[CTRL_LOCK_OFF_BIT];
    wire rev_en = prot_on & ~reverse_guard_select_n;
    wire tsd_on = prot_on & thermal_shutdown_limit;
    wire driving = mode_reg == MODE_RUN && !duty_zero;
    wire lock_hit = lock_cnt_reg >= lock_to_reg;
    wire rev_hit = rev_cnt_reg >= lock_to_reg;
    wire stop_held = stop_cnt_reg == 16'(STOP_MIN_CYC);
    wire zero_held = zero_cnt_reg > {clr_unit_reg, 1'b0};
    wire fault_clr = stop_held | zero_held | kill;
    wire dir_in = ctrl_reg[CTRL_DIR_BIT];
    wire brake_on = ~brake_request_n;
    wire dead_done = dead_cnt_reg == 16'(DEAD_CYC - 1);

    // mode sequencing; every entry to run or brake goes through the dead interval
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            MODE_STOP: if (!run_stop_select) mode_next = MODE_DEAD;
            MODE_DEAD: if (dead_done) mode_next = brake_on ? MODE_BRAKE : MODE_RUN;
            MODE_RUN: if (brake_on || dir_in != dir_reg) mode_next = MODE_DEAD;
            MODE_BRAKE: if (!brake_on) mode_next = MODE_DEAD;
            default: mode_next = MODE_STOP;
        endcase
        if (run_stop_select || kill) mode_next = MODE_STOP;
    end

    // output pattern
    wire bcp_drive_s tbl = DRIVE_TABLE[{dir_reg, hall}];
    wire all_off = hall_all | (rev_en & duty_zero) | rev_fault_reg;
    wire upper_off = undervoltage_sense | tsd_on | lock_fault_reg;
    always_comb begin
        pat = '0;
        case (mode_reg)
            MODE_RUN: begin
                pat.upper = tbl.upper & {3{duty_on & ~oc_cut_reg}};
                pat.lower = tbl.lower;
            end
            MODE_BRAKE: pat.upper = 3'h7;
            default: pat = '0;
        endcase
        drv_next.upper = pat.upper & ~{3{upper_off | all_off}};
        drv_next.lower = pat.lower & ~{3{all_off}};
    end

    // register port
    wire wr_ctrl = bus_req.wr && bus_req.addr == OFS_CTRL;
    wire wr_lock = bus_req.wr && bus_req.addr == OFS_LOCK;
    wire wr_clr = bus_req.wr && bus_req.addr == OFS_CLR;
    wire [31:0] status = {22'h0, mode_reg, hall, 1'b0, tsd_on, undervoltage_sense,
                          rev_fault_reg, lock_fault_reg};
    assign rdata_next = !bus_req.rd ? 32'h0 :
                        bus_req.addr == OFS_CTRL ? {30'h0, ctrl_reg} :
                        bus_req.addr == OFS_LOCK ? lock_to_reg :
                        bus_req.addr == OFS_CLR ? clr_unit_reg :
                        bus_req.addr == OFS_STAT ? status : 32'h0;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= CTRL_RST;
            lock_to_reg <= 32'(LOCK_TIMEOUT_CYC);
            clr_unit_reg <= 32'(CLEAR_UNIT_CYC);
            reg_rdata <= 32'h0;
        end else begin
            if (wr_ctrl) ctrl_reg <= bus_req.wdata[1:0];
            if (wr_lock) lock_to_reg <= bus_req.wdata;
            if (wr_clr) clr_unit_reg <= bus_req.wdata;
            reg_rdata <= rdata_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_reg <= MODE_STOP;
            drv_reg <= '0;
            oe_reg <= 1'b0;
            dir_reg <= 1'b0;
            hcomp_reg <= 1'b0;
            hall_q_reg <= 3'h0;
            carrier_reg <= CMP_LOWER_MV;
            dead_cnt_reg <= 16'h0;
        end else begin
            mode_reg <= mode_next;
            drv_reg <= drv_next;
            oe_reg <= mode_next != MODE_STOP;
            hcomp_reg <= ^hall;
            hall_q_reg <= hall;
            carrier_reg <= carrier_next;
            dead_cnt_reg <= (mode_reg == MODE_DEAD) ? dead_cnt_reg + 16'h1 : 16'h0;
            // direction is taken only inside the off interval
            if (mode_reg == MODE_DEAD) dir_reg <= dir_in;
        end
    end

    // current limit: cut lasts to the next carrier period, set wins over clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) oc_cut_reg <= 1'b0;
        else oc_cut_reg <= (overcurrent_sense && mode_reg == MODE_RUN)
                           || (oc_cut_reg && !carrier_wrap && mode_reg == MODE_RUN);
    end

    // lock detection, held at zero outside driving so braking cannot accumulate
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_cnt_reg <= 32'h0;
            lock_fault_reg <= 1'b0;
        end else begin
            if (!driving || hall_chg || !prot_on || kill) lock_cnt_reg <= 32'h0;
            else if (!lock_hit) lock_cnt_reg <= lock_cnt_reg + 32'h1;
            if (driving && prot_on && lock_hit && !kill) lock_fault_reg <= 1'b1;
            else if (fault_clr) lock_fault_reg <= 1'b0;
        end
    end

    // reverse detection and its timeout
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            back_cnt_reg <= 2'h0;
            rev_cnt_reg <= 32'h0;
            rev_fault_reg <= 1'b0;
        end else begin
            if (step_ahead || kill) back_cnt_reg <= 2'h0;
            else if (step_back && !rev_judged) back_cnt_reg <= back_cnt_reg + 2'h1;
            // a reversal seen before drive starts is timed from the start of drive
            // cleared while duty is zero, so a zero-duty hold can clear the fault
            if (!rev_judged || !rev_en || !driving || kill) rev_cnt_reg <= 32'h0;
            else if (!rev_hit) rev_cnt_reg <= rev_cnt_reg + 32'h1;
            if (rev_judged && rev_en && rev_hit && !kill) rev_fault_reg <= 1'b1;
            else if (fault_clr) rev_fault_reg <= 1'b0;
        end
    end

    // clear timers for the latched faults
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stop_cnt_reg <= 16'h0;
            zero_cnt_reg <= 33'h0;
        end else begin
            if (!run_stop_select) stop_cnt_reg <= 16'h0;
            else if (!stop_held) stop_cnt_reg <= stop_cnt_reg + 16'h1;
            if (!duty_zero) zero_cnt_reg <= 33'h0;
            else if (!zero_held) zero_cnt_reg <= zero_cnt_reg + 33'h1;
        end
    end

    assign upper_drive_u = drv_reg.upper[0];
    assign upper_drive_v = drv_reg.upper[1];
    assign upper_drive_w = drv_reg.upper[2];
    assign lower_drive_u = drv_reg.lower[0];
    assign lower_drive_v = drv_reg.lower[1];
    assign lower_drive_w = drv_reg.lower[2];
    assign drive_oe = oe_reg;
    assign hall_composite_out = hcomp_reg;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    AST_HALL_ALL_OFF: assert property (hall_all |=> drv_reg == '0)
        else $error("all halls high but outputs on");
    AST_STOP_HIZ: assert property (run_stop_select |=> !drive_oe)
        else $error("stop requested but outputs enabled");
    // brake drives all upper outputs on whatever the pulse input, so brake is excluded
    AST_PULSE_OFF: assert property (pulse_duty_input_n && mode_reg != MODE_BRAKE
        |=> drv_reg.upper == 3'h0)
        else $error("pulse input high but upper outputs on");
    AST_CMP_ZERO: assert property (duty_compare_input >= CMP_UPPER_MV && mode_reg == MODE_RUN
        |=> drv_reg.upper == 3'h0)
        else $error("compare input above carrier but upper on");
    AST_UV_UPPER: assert property (undervoltage_sense |=> drv_reg.upper == 3'h0)
        else $error("undervoltage but upper outputs on");
    AST_TSD_UPPER: assert property (thermal_shutdown_limit && !ctrl_reg[CTRL_LOCK_OFF_BIT]
        |=> drv_reg.upper == 3'h0)
        else $error("overheat but upper outputs on");
    AST_LOCK_SET: assert property (driving && prot_on && lock_hit && !kill |=> lock_fault_reg)
        else $error("lock timeout elapsed without fault");
    AST_BRAKE_NO_LOCK: assert property (mode_reg == MODE_BRAKE |=> lock_cnt_reg == 32'h0)
        else $error("lock timer ran while braking");
    AST_FAULT_CLEAR: assert property (stop_held && !(driving && lock_hit)
        |=> !lock_fault_reg && !rev_fault_reg)
        else $error("stop held but faults not cleared");
    AST_REV_ZERO_OFF: assert property (rev_en && duty_zero |=> drv_reg == '0)
        else $error("zero duty with reverse guard but outputs on");
    AST_DEAD_FIRST: assert property (mode_reg == MODE_RUN && $past(mode_reg) != MODE_RUN
        |-> $past(mode_reg) == MODE_DEAD && $past(drv_reg) == '0)
        else $error("drive resumed without off interval");
    AST_BRAKE_PAT: assert property (mode_reg == MODE_BRAKE && !upper_off && !all_off
        |=> drv_reg.upper == 3'h7 && drv_reg.lower == 3'h0)
        else $error("brake pattern wrong");
    AST_KILL: assert property (kill |=> mode_reg == MODE_STOP && !drive_oe)
        else $error("grounded lock node but block active");

    // state and output sequencing
    AST_OE_MODE: assert property (drive_oe == (mode_reg != MODE_STOP))
        else $error("output enable disagrees with mode");

    AST_STOP_DRV_OFF: assert property (mode_reg == MODE_STOP
        |=> drv_reg == '0)
        else $error("outputs on in stop mode");

    AST_DEAD_OFF: assert property (mode_reg == MODE_DEAD
        |=> drv_reg == '0)
        else $error("outputs on inside off interval");

    AST_LOWER_NO_PWM: assert property (mode_reg == MODE_RUN && !all_off
        |=> drv_reg.lower == $past(tbl.lower))
        else $error("lower outputs modulated");

    // a table with one phase on both sides would short the bridge
    AST_NO_SHOOT: assert property ((drv_reg.upper & drv_reg.lower) == 3'h0)
        else $error("upper and lower of one phase on together");

    AST_START_DEAD: assert property (mode_reg == MODE_STOP && !run_stop_select && !kill
        |=> mode_reg == MODE_DEAD)
        else $error("run request did not start off interval");

    AST_BRAKE_ENTRY: assert property (mode_reg == MODE_RUN && brake_on && !run_stop_select && !kill
        |=> mode_reg == MODE_DEAD)
        else $error("brake entered without off interval");

    AST_DIR_HELD: assert property (mode_reg != MODE_DEAD
        |=> $stable(dir_reg))
        else $error("direction changed outside off interval");

    // protection timers and faults
    AST_OC_CUT: assert property (overcurrent_sense && mode_reg == MODE_RUN
        |=> oc_cut_reg)
        else $error("overcurrent did not cut the pulse");

    AST_BRAKE_NO_CUT: assert property (mode_reg == MODE_BRAKE
        |=> !oc_cut_reg)
        else $error("current limit active while braking");

    AST_LOCK_OFF_QUIET: assert property (!prot_on
        |=> lock_cnt_reg == 32'h0)
        else $error("lock timer ran with protection unused");

    AST_REV_DISABLED: assert property (!rev_en
        |=> rev_cnt_reg == 32'h0)
        else $error("reverse timer ran while disabled");

    AST_REV_HOLD: assert property (rev_fault_reg
        |=> drv_reg == '0)
        else $error("reverse fault but outputs on");

    AST_LOCK_UPPER: assert property (lock_fault_reg
        |=> drv_reg.upper == 3'h0)
        else $error("lock fault but upper outputs on");

    AST_ZERO_CLEAR: assert property (zero_held && !rev_hit
        |=> !lock_fault_reg && !rev_fault_reg)
        else $error("zero duty held but faults not cleared");

    AST_KILL_FAULTS: assert property (kill
        |=> !lock_fault_reg && !rev_fault_reg)
        else $error("grounded lock node but faults kept");

    AST_AHEAD_CLR: assert property (step_ahead && !kill
        |=> back_cnt_reg == 2'h0)
        else $error("forward step did not clear reversal");
endmodule
`default_nettype wire

// ### verif/bcp_ctrl_model.sv
// motor controller model: hall sensor stepping and duty command selection
`timescale 1ns/10ps
`default_nettype none
module bcp_ctrl_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic step_req,
    input wire logic backward,
    input wire logic all_high,
    input wire logic use_pulse,
    input wire logic pulse_off,
    input wire logic [11:0] cmp_mv,
    output logic hall_phase_one,
    output logic hall_phase_two,
    output logic hall_phase_three,
    output logic pulse_duty_input_n,
    output logic [11:0] duty_compare_input
);
    // forward order of {three, two, one}, index 0 last
    localparam logic [5:0][2:0] SEQ = {3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
    logic [2:0] idx_reg;
    wire [2:0] idx_up = (idx_reg == 3'h5) ? 3'h0 : idx_reg + 3'h1;
    wire [2:0] idx_dn = (idx_reg == 3'h0) ? 3'h5 : idx_reg - 3'h1;
    // one step per request, so the bench decides rotor speed and stalls
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idx_reg <= 3'h0;
        end else if (step_req) begin
            idx_reg <= backward ? idx_dn : idx_up;
        end
    end
    assign {hall_phase_three, hall_phase_two, hall_phase_one} = all_high ? 3'h7 : SEQ[idx_reg];
    // pulse input parked low while the compare input sets duty
    assign pulse_duty_input_n = use_pulse ? pulse_off : 1'b0;
    // compare tied to ground so pulses alone set duty
    assign duty_compare_input = use_pulse ? 12'h000 : cmp_mv;
endmodule
`default_nettype wire

// ### verif/test_bcp_top.sv
// self-checking bench for the commutation and protection block
`timescale 1ns/10ps
`default_nettype none
module test_bcp_top;
    import bcp_pkg::*;
    localparam int LOCK_CYC = 50;
    localparam int CLR_CYC = 10;
    localparam int GAP = 20;
    localparam int DEAD_WAIT = DEAD_CYC + 10;
    logic clk = 1'b0;
    logic rst = 1'b1;
    bcp_bus_s bus_req = '0;
    logic run_stop_select = 1'b1;
    logic brake_request_n = 1'b1;
    logic reverse_guard_select_n = 1'b1;
    logic undervoltage_sense = 1'b0;
    logic thermal_shutdown_limit = 1'b0;
    logic overcurrent_sense = 1'b0;
    logic lock_timer_node_n = 1'b1;
    logic step_req = 1'b0;
    logic backward = 1'b0;
    logic all_high = 1'b0;
    logic use_pulse = 1'b0;
    logic pulse_off = 1'b0;
    logic [11:0] cmp_mv = 12'h000;
    wire [31:0] reg_rdata;
    wire hall_phase_one, hall_phase_two, hall_phase_three, pulse_duty_input_n;
    wire [11:0] duty_compare_input;
    wire upper_drive_u, upper_drive_v, upper_drive_w, lower_drive_u, lower_drive_v, lower_drive_w;
    wire drive_oe, hall_composite_out;
    wire [5:0] drv;
    logic [31:0] stat;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;

    assign drv = {upper_drive_w, upper_drive_v, upper_drive_u, lower_drive_w, lower_drive_v, lower_drive_u};
    always #2.5 clk = ~clk;

    bcp_top #(.LOCK_TIMEOUT_CYC(LOCK_CYC), .CLEAR_UNIT_CYC(CLR_CYC), .DRIVE_TABLE(COMM_TABLE)) bcp_top_i (
        .clk, .rst, .bus_req, .reg_rdata, .hall_phase_one, .hall_phase_two, .hall_phase_three,
        .pulse_duty_input_n, .duty_compare_input, .run_stop_select, .brake_request_n,
        .reverse_guard_select_n, .undervoltage_sense, .thermal_shutdown_limit, .overcurrent_sense,
        .lock_timer_node_n, .upper_drive_u, .upper_drive_v, .upper_drive_w, .lower_drive_u,
        .lower_drive_v, .lower_drive_w, .drive_oe, .hall_composite_out);

    bcp_ctrl_model bcp_ctrl_model_i (
        .clk, .rst, .step_req, .backward, .all_high, .use_pulse, .pulse_off, .cmp_mv,
        .hall_phase_one, .hall_phase_two, .hall_phase_three, .pulse_duty_input_n, .duty_compare_input);

    task automatic stop_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one idle edge after each access keeps strobe updates in separate steps
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req <= '0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req <= '0;
        #1 d = reg_rdata;
        @(posedge clk);
    endtask

    // n hall steps, then compare drive against the table masked by gating
    task automatic chkpat(input int n, input logic dir, input logic [5:0] mask);
        repeat (n) begin
            step_req <= 1'b1;
            @(posedge clk);
            step_req <= 1'b0;
            wt(GAP - 1);
        end
        wt(3);
        chk(drv, COMM_TABLE[{dir, hall_phase_three, hall_phase_two, hall_phase_one}] & mask);
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end

    initial begin
        wt(8);
        rst <= 1'b0;
        wt(2);
        chk(drv, 32'h0);
        chk(drive_oe, 32'h0);
        rd(OFS_STAT, stat);
        chk(stat[9:8], 32'h0);
        rd(OFS_LOCK, stat);
        chk(stat, LOCK_CYC);
        rd(OFS_CLR, stat);
        chk(stat, CLR_CYC);
        wr(4'h2, 32'h3);
        rd(4'h2, stat);
        chk(stat, 32'h0);
        rd(OFS_CTRL, stat);
        chk(stat, 32'h0);
        run_stop_select <= 1'b0;
        wt(DEAD_WAIT);
        chk(drive_oe, 32'h1);
        chkpat(0, 1'b0, 6'h3f);
        chkpat(2, 1'b0, 6'h3f);
        chk(hall_composite_out, hall_phase_one ^ hall_phase_two ^ hall_phase_three);
        use_pulse <= 1'b1;
        pulse_off <= 1'b1;
        chkpat(1, 1'b0, 6'h07);
        pulse_off <= 1'b0;
        chkpat(1, 1'b0, 6'h3f);
        use_pulse <= 1'b0;
        cmp_mv <= CMP_UPPER_MV;
        chkpat(1, 1'b0, 6'h07);
        cmp_mv <= CMP_LOWER_MV - 12'h004;
        chkpat(1, 1'b0, 6'h3f);
        cmp_mv <= 12'h000;
        undervoltage_sense <= 1'b1;
        chkpat(1, 1'b0, 6'h07);
        undervoltage_sense <= 1'b0;
        chkpat(1, 1'b0, 6'h3f);
        thermal_shutdown_limit <= 1'b1;
        chkpat(1, 1'b0, 6'h07);
        thermal_shutdown_limit <= 1'b0;
        overcurrent_sense <= 1'b1;
        chkpat(1, 1'b0, 6'h07);
        overcurrent_sense <= 1'b0;
        chkpat(23, 1'b0, 6'h3f);
        all_high <= 1'b1;
        chkpat(1, 1'b0, 6'h00);
        all_high <= 1'b0;
        reverse_guard_select_n <= 1'b0;
        use_pulse <= 1'b1;
        pulse_off <= 1'b1;
        chkpat(1, 1'b0, 6'h00);
        pulse_off <= 1'b0;
        use_pulse <= 1'b0;
        chkpat(1, 1'b0, 6'h3f);
        wt(LOCK_CYC + 10);
        chkpat(0, 1'b0, 6'h07);
        rd(OFS_STAT, stat);
        chk(stat[ST_LOCK_BIT], 32'h1);
        use_pulse <= 1'b1;
        pulse_off <= 1'b1;
        chkpat(2, 1'b0, 6'h00);
        pulse_off <= 1'b0;
        use_pulse <= 1'b0;
        rd(OFS_STAT, stat);
        chk(stat[ST_LOCK_BIT], 32'h0);
        chkpat(1, 1'b0, 6'h3f);
        reverse_guard_select_n <= 1'b1;
        brake_request_n <= 1'b0;
        wt(5);
        chk(drv, 32'h0);
        wt(DEAD_CYC);
        chk(drv, 32'h38);
        overcurrent_sense <= 1'b1;
        wt(LOCK_CYC + 10);
        chk(drv, 32'h38);
        rd(OFS_STAT, stat);
        chk(stat[ST_LOCK_BIT], 32'h0);
        chk(stat[9:8], 32'h3);
        overcurrent_sense <= 1'b0;
        brake_request_n <= 1'b1;
        wt(5);
        chk(drv, 32'h0);
        wt(DEAD_CYC);
        chkpat(1, 1'b0, 6'h3f);
        wr(OFS_CTRL, 32'h1);
        wt(5);
        chk(drv, 32'h0);
        wt(DEAD_CYC);
        chkpat(1, 1'b1, 6'h3f);
        wr(OFS_CTRL, 32'h0);
        wt(DEAD_WAIT);
        reverse_guard_select_n <= 1'b0;
        backward <= 1'b1;
        chkpat(3, 1'b0, 6'h3f);
        chkpat(3, 1'b0, 6'h00);
        rd(OFS_STAT, stat);
        chk(stat[ST_REV_BIT], 32'h1);
        run_stop_select <= 1'b1;
        wt(3);
        chk(drive_oe, 32'h0);
        wt(STOP_MIN_CYC + 100);
        rd(OFS_STAT, stat);
        chk(stat[ST_REV_BIT], 32'h0);
        run_stop_select <= 1'b0;
        wt(DEAD_WAIT + LOCK_CYC + 10);
        chk(drv, 32'h0);
        rd(OFS_STAT, stat);
        chk(stat[ST_REV_BIT], 32'h1);
        repeat (4) begin
            cmp_mv <= cmp_mv + CMP_UPPER_MV / 12'h4;
            wt(2);
        end
        wt(3 * CLR_CYC);
        rd(OFS_STAT, stat);
        chk(stat[1:0], 32'h0);
        cmp_mv <= 12'h000;
        backward <= 1'b0;
        chkpat(1, 1'b0, 6'h3f);
        // lock unused also silences thermal and stall faults
        wr(OFS_CTRL, 32'h2);
        thermal_shutdown_limit <= 1'b1;
        chkpat(1, 1'b0, 6'h3f);
        wt(LOCK_CYC + 10);
        chkpat(0, 1'b0, 6'h3f);
        thermal_shutdown_limit <= 1'b0;
        lock_timer_node_n <= 1'b0;
        wt(3);
        chk(drive_oe, 32'h0);
        chk(drv, 32'h0);
        rd(OFS_STAT, stat);
        chk(stat[9:8], 32'h0);
        lock_timer_node_n <= 1'b1;
        stop_test();
    end
endmodule
`default_nettype wire
